// [src/crt_ctrl_end.sv]
// memory controller end of the column link: issues stores and fetches with turnaround gaps
// assumes: one dram on the link; forward clock is clk divided by two

module crt_ctrl_end
  import crt_pkg::*;
#(
  parameter int ACC = CRT_ACC_CYC,
  parameter int WR_LAG = CRT_WR_LAG_CYC,
  parameter int RD_LAG = CRT_RD_LAG_CYC,
  parameter int ST_FE_GAP = CRT_ST_FE_GAP_CYC,
  parameter int FE_ST_BUB_CTL = CRT_FE_ST_BUB_CTL_CYC,
  parameter int REQ_FLIGHT = CRT_REQ_FLIGHT_CYC,
  parameter int WR_FLIGHT = CRT_WR_FLIGHT_CYC,
  parameter int RD_FLIGHT = CRT_RD_FLIGHT_CYC
) (
  // clock and reset
  input logic clk,
  input logic rst,
  // user request
  input logic reqValid,
  input logic reqStore,
  input logic [CRT_ADDR_W-1:0] reqAddr,
  input logic [CRT_DATA_W*ACC-1:0] reqWdata,
  output logic reqReady,
  // user answer
  output logic rdValid,
  output logic [CRT_DATA_W*ACC-1:0] rdData,
  // link side
  crt_link_if.ctrl link
);

  localparam int PW = CRT_DATA_W * ACC; // packet width
  localparam int DEV_BUB = crt_dev_bubble(FE_ST_BUB_CTL, WR_FLIGHT, RD_FLIGHT);
  localparam int FE_ST_GAP = crt_fe_st_gap(RD_LAG, WR_LAG, ACC, DEV_BUB);
  localparam int ST_FE_BUB = crt_st_fe_bubble(ST_FE_GAP, RD_LAG, WR_LAG, ACC);
  localparam int WL = WR_LAG + WR_FLIGHT - REQ_FLIGHT;
  localparam int RL = RD_LAG + REQ_FLIGHT + RD_FLIGHT;
  localparam int DEPTH = crt_max(WL, RL) + ACC; // command history length
  localparam logic [CRT_SINCE_W-1:0] GAP_SAME = CRT_SINCE_W'(ACC);
  localparam logic [CRT_SINCE_W-1:0] GAP_ST_FE = CRT_SINCE_W'(ST_FE_GAP);
  localparam logic [CRT_SINCE_W-1:0] GAP_FE_ST = CRT_SINCE_W'(FE_ST_GAP);
  localparam logic [3:0] RST_LOAD = 4'(CRT_LINK_RST_CYC + CRT_LINK_SETTLE_CYC);
  localparam logic [3:0] RST_SETTLE = 4'(CRT_LINK_SETTLE_CYC);

  // ****************************************
  // state
  // ****************************************
  logic lk_r; // forward clock divider
  logic lkNxt;
  logic [3:0] rstCnt_r; // link reset and settle countdown
  logic [3:0] rstCntNxt;
  logic linkRst_r;
  logic linkRstNxt;
  crt_state_t state_r;
  crt_state_t stateNxt;
  crt_cmd_t hold_r; // accepted request awaiting issue
  crt_cmd_t holdNxt;
  logic [PW-1:0] holdData_r;
  logic [PW-1:0] holdDataNxt;
  logic [CRT_SINCE_W-1:0] since_r; // link cycles since last command
  logic [CRT_SINCE_W-1:0] sinceNxt;
  logic lastStore_r; // type of last command
  logic lastStoreNxt;
  crt_cmd_t pipe_r [DEPTH]; // issued commands, shifted at each falling tick
  crt_cmd_t pipeNxt [DEPTH];
  logic [PW-1:0] pdata_r [DEPTH]; // store data travelling with commands
  logic [PW-1:0] pdataNxt [DEPTH];
  crt_cmd_t cmd_r; // request wire drive
  crt_cmd_t cmdNxt;
  logic [CRT_DATA_W-1:0] dOut_r; // lane drive value
  logic [CRT_DATA_W-1:0] dOutNxt;
  logic dOeN_r; // lane enable, low while driving
  logic dOeNNxt;
  logic ready_r;
  logic readyNxt;
  logic rdValid_r;
  logic rdValidNxt;
  logic [PW-1:0] rdData_r;
  logic [PW-1:0] rdDataNxt;
  logic [PW-1:0] rbuf_r; // read packet being gathered
  logic [PW-1:0] rbufNxt;
  logic [CRT_DATA_W-1:0] syn1_r; // lane sync first stage
  logic [CRT_DATA_W-1:0] syn2_r; // lane sync second stage
  logic fall; // this edge drops the forward clock
  logic gapOk; // held command may go now

  // ****************************************
  // issue gating
  // ****************************************
  // compare spacing counter with the gap the command pair needs
  always_comb begin
    if (hold_r.store == lastStore_r) begin
      gapOk = (since_r >= GAP_SAME);
    end else if (hold_r.store) begin
      gapOk = (since_r >= GAP_FE_ST);
    end else begin
      gapOk = (since_r >= GAP_ST_FE);
    end
  end

  // ****************************************
  // next state
  // ****************************************
  // divider, link reset, acceptance, issue and data beats
  always_comb begin
    fall = lk_r;
    lkNxt = ~lk_r;
    rstCntNxt = rstCnt_r;
    linkRstNxt = linkRst_r;
    stateNxt = state_r;
    holdNxt = hold_r;
    holdDataNxt = holdData_r;
    sinceNxt = since_r;
    lastStoreNxt = lastStore_r;
    pipeNxt = pipe_r;
    pdataNxt = pdata_r;
    cmdNxt = cmd_r;
    dOutNxt = dOut_r;
    dOeNNxt = dOeN_r;
    readyNxt = ready_r;
    rdValidNxt = 1'b0;
    rdDataNxt = rdData_r;
    rbufNxt = rbuf_r;
    // take a user request while idle
    if (state_r == CRT_S_IDLE && reqValid && ready_r) begin
      holdNxt = '{valid: 1'b1, store: reqStore, addr: reqAddr};
      holdDataNxt = reqWdata;
      stateNxt = CRT_S_HOLD;
      readyNxt = 1'b0;
    end
    if (fall) begin
      // link reset countdown, then settle before first command
      if (rstCnt_r != 4'h0) begin
        rstCntNxt = rstCnt_r - 4'h1;
      end
      linkRstNxt = (rstCntNxt > RST_SETTLE);
      if (state_r == CRT_S_RESET && rstCnt_r == 4'h0) begin
        stateNxt = CRT_S_IDLE;
        readyNxt = 1'b1;
      end
      // shift history
      pipeNxt[0] = '0;
      pdataNxt[0] = '0;
      for (int k = 1; k < DEPTH; k++) begin
        pipeNxt[k] = pipe_r[k-1];
        pdataNxt[k] = pdata_r[k-1];
      end
      cmdNxt = '0;
      sinceNxt = (since_r == CRT_SINCE_MAX) ? since_r : since_r + 8'h01;
      // issue held command once its gap has elapsed
      if (state_r == CRT_S_HOLD && gapOk) begin
        pipeNxt[0] = hold_r;
        pdataNxt[0] = holdData_r;
        cmdNxt = hold_r;
        sinceNxt = 8'h01;
        lastStoreNxt = hold_r.store;
        stateNxt = CRT_S_IDLE;
        readyNxt = 1'b1;
      end
      // write beats leave the corrected write lag after their command
      dOutNxt = '0;
      dOeNNxt = 1'b1;
      for (int b = 0; b < ACC; b++) begin
        if (pipeNxt[WL+b].valid && pipeNxt[WL+b].store) begin
          dOutNxt = pdataNxt[WL+b][b*CRT_DATA_W +: CRT_DATA_W];
          dOeNNxt = 1'b0;
        end
        // read beats are expected the read lag plus both flights later
        if (pipe_r[RL+b-1].valid && !pipe_r[RL+b-1].store) begin
          rbufNxt[b*CRT_DATA_W +: CRT_DATA_W] = syn2_r;
          if (b == ACC - 1) begin
            rdValidNxt = 1'b1;
            rdDataNxt = rbufNxt;
          end
        end
      end
    end
  end

  // ****************************************
  // registers
  // ****************************************
  // lane sync stages carry no reset
  always_ff @(posedge clk) begin
    syn1_r <= link.dataLanes;
    syn2_r <= syn1_r;
  end

  // control and data state
  always_ff @(posedge clk) begin
    if (rst) begin
      lk_r <= 1'b0;
      rstCnt_r <= RST_LOAD;
      linkRst_r <= 1'b1;
      state_r <= CRT_S_RESET;
      hold_r <= '0;
      holdData_r <= '0;
      since_r <= CRT_SINCE_MAX;
      lastStore_r <= 1'b0;
      for (int k = 0; k < DEPTH; k++) begin
        pipe_r[k] <= '0;
        pdata_r[k] <= '0;
      end
      cmd_r <= '0;
      dOut_r <= '0;
      dOeN_r <= 1'b1;
      ready_r <= 1'b0;
      rdValid_r <= 1'b0;
      rdData_r <= '0;
      rbuf_r <= '0;
    end else begin
      lk_r <= lkNxt;
      rstCnt_r <= rstCntNxt;
      linkRst_r <= linkRstNxt;
      state_r <= stateNxt;
      hold_r <= holdNxt;
      holdData_r <= holdDataNxt;
      since_r <= sinceNxt;
      lastStore_r <= lastStoreNxt;
      pipe_r <= pipeNxt;
      pdata_r <= pdataNxt;
      cmd_r <= cmdNxt;
      dOut_r <= dOutNxt;
      dOeN_r <= dOeNNxt;
      ready_r <= readyNxt;
      rdValid_r <= rdValidNxt;
      rdData_r <= rdDataNxt;
      rbuf_r <= rbufNxt;
    end
  end

  // outputs straight from flops
  assign link.linkClk = lk_r;
  assign link.linkRst = linkRst_r;
  assign link.cmdValid = cmd_r.valid;
  assign link.cmdStore = cmd_r.store;
  assign link.cmdAddr = cmd_r.addr;
  assign link.ctrlData = dOut_r;
  assign link.ctrlDataOeN = dOeN_r;
  assign reqReady = ready_r;
  assign rdValid = rdValid_r;
  assign rdData = rdData_r;

endmodule

// [src/crt_pkg.sv]
// shared constants, command type and turnaround arithmetic for both link ends
// assumes: all timing figures are counted in link clock cycles at the dram pins

package crt_pkg;

  // ****************************************
  // widths and defaults
  // ****************************************
  localparam int CRT_DATA_W = 8; // one data lane word per link cycle
  localparam int CRT_ADDR_W = 4; // column address width
  localparam int CRT_MEM_DEPTH = 16; // packets held by the dram end
  localparam int CRT_ACC_CYC = 2; // access cycle time, also packet length
  localparam int CRT_WR_LAG_CYC = 4; // write data lag
  localparam int CRT_RD_LAG_CYC = 6; // read data lag
  localparam int CRT_ST_FE_GAP_CYC = 9; // store-to-fetch command gap
  localparam int CRT_FE_ST_BUB_CTL_CYC = 3; // fetch-store bubble at controller
  localparam int CRT_REQ_FLIGHT_CYC = 0; // request flight time
  localparam int CRT_WR_FLIGHT_CYC = 0; // write flight time
  localparam int CRT_RD_FLIGHT_CYC = 2; // read flight time incl. capture sync
  localparam int CRT_LINK_RST_CYC = 4; // link reset pulse length
  localparam int CRT_LINK_SETTLE_CYC = 3; // cycles for dram reset sync to clear
  localparam int CRT_SINCE_W = 8; // width of command spacing counter
  localparam logic [CRT_SINCE_W-1:0] CRT_SINCE_MAX = 8'hFF; // saturation value

  // ****************************************
  // types
  // ****************************************
  // one column command as seen on the request wires
  typedef struct packed {
    logic valid;
    logic store;
    logic [CRT_ADDR_W-1:0] addr;
  } crt_cmd_t;

  // controller sequencing states
  typedef enum logic [2:0] {
    CRT_S_RESET = 3'b001,
    CRT_S_IDLE = 3'b010,
    CRT_S_HOLD = 3'b100
  } crt_state_t;

  // ****************************************
  // turnaround arithmetic
  // ****************************************
  // device bubble is controller bubble plus both flight times
  function automatic int crt_dev_bubble(input int bubCtl, input int wrF, input int rdF);
    crt_dev_bubble = bubCtl + wrF + rdF;
  endfunction

  // least fetch-to-store command gap
  function automatic int crt_fe_st_gap(input int rdLag, input int wrLag, input int acc,
                                      input int devBub);
    crt_fe_st_gap = rdLag - wrLag + acc + devBub;
  endfunction

  // idle lane cycles left between a store packet and the following fetch packet
  function automatic int crt_st_fe_bubble(input int gap, input int rdLag, input int wrLag,
                                         input int acc);
    crt_st_fe_bubble = gap + rdLag - wrLag - acc;
  endfunction

  // larger of two counts
  function automatic int crt_max(input int a, input int b);
    crt_max = (a > b) ? a : b;
  endfunction

endpackage

// [src/crt_link_if.sv]
// link between the memory controller end and the dram end
// assumes: controller makes the forward clock; lanes resolve from the two enables

interface crt_link_if;
  import crt_pkg::*;

  // ****************************************
  // link signals
  // ****************************************
  logic linkClk; // forward clock, made by the controller
  logic linkRst; // link reset, held by the controller
  logic cmdValid; // request wires: command present
  logic cmdStore; // request wires: 1 store, 0 fetch
  logic [CRT_ADDR_W-1:0] cmdAddr; // request wires: column address
  logic [CRT_DATA_W-1:0] ctrlData; // controller drive value on data lanes
  logic ctrlDataOeN; // controller drives lanes while low
  logic [CRT_DATA_W-1:0] devData; // dram drive value on data lanes
  logic devDataOeN; // dram drives lanes while low
  logic [CRT_DATA_W-1:0] dataLanes; // resolved data lanes

  // lanes show whichever end drives, zero when nobody does
  assign dataLanes = !devDataOeN ? devData : (!ctrlDataOeN ? ctrlData : '0);

  modport ctrl (
    output linkClk, linkRst, cmdValid, cmdStore, cmdAddr, ctrlData, ctrlDataOeN,
    input dataLanes
  );

  modport dram (
    input linkClk, linkRst, cmdValid, cmdStore, cmdAddr, dataLanes,
    output devData, devDataOeN
  );
endinterface

// [src/crt_dram_end.sv]
// dram end of the column link: stores and returns data packets at fixed lags
// assumes: request wires and write data are launched on the falling forward clock

module crt_dram_end
  import crt_pkg::*;
#(
  parameter int ACC = CRT_ACC_CYC,
  parameter int WR_LAG = CRT_WR_LAG_CYC,
  parameter int RD_LAG = CRT_RD_LAG_CYC
) (
  // link side
  crt_link_if.dram link,
  // user side
  output logic storeDone,
  output logic [CRT_ADDR_W-1:0] doneAddr
);

  localparam int DEPTH = crt_max(WR_LAG, RD_LAG) + ACC; // command history length
  localparam int PW = CRT_DATA_W * ACC; // packet width

  // ****************************************
  // state
  // ****************************************
  logic rstS1_r; // reset sync first stage
  logic rstS2_r; // reset sync second stage
  crt_cmd_t pipe_r [DEPTH]; // index k holds command taken k+1 edges ago
  crt_cmd_t pipeNxt [DEPTH];
  logic [PW-1:0] mem_r [CRT_MEM_DEPTH]; // stored packets
  logic [PW-1:0] memNxt [CRT_MEM_DEPTH];
  logic [PW-1:0] wbuf_r; // write packet being gathered
  logic [PW-1:0] wbufNxt;
  logic [CRT_DATA_W-1:0] out_r; // lane drive value
  logic [CRT_DATA_W-1:0] outNxt;
  logic oeN_r; // lane enable, low while driving
  logic oeNNxt;
  logic storeDone_r;
  logic storeDoneNxt;
  logic [CRT_ADDR_W-1:0] doneAddr_r;
  logic [CRT_ADDR_W-1:0] doneAddrNxt;

  // ****************************************
  // next state
  // ****************************************
  // shift commands, capture write beats, schedule read beats
  always_comb begin
    pipeNxt[0] = '{valid: link.cmdValid, store: link.cmdStore, addr: link.cmdAddr};
    for (int k = 1; k < DEPTH; k++) begin
      pipeNxt[k] = pipe_r[k-1];
    end
    memNxt = mem_r;
    wbufNxt = wbuf_r;
    outNxt = '0;
    oeNNxt = 1'b1;
    storeDoneNxt = 1'b0;
    doneAddrNxt = doneAddr_r;
    for (int b = 0; b < ACC; b++) begin
      // write beat b arrives write lag plus b after its command
      if (pipe_r[WR_LAG+b-1].valid && pipe_r[WR_LAG+b-1].store) begin
        wbufNxt[b*CRT_DATA_W +: CRT_DATA_W] = link.dataLanes;
        if (b == ACC - 1) begin
          memNxt[pipe_r[WR_LAG+b-1].addr] = wbufNxt;
          storeDoneNxt = 1'b1;
          doneAddrNxt = pipe_r[WR_LAG+b-1].addr;
        end
      end
      // read beat b leaves read lag plus b after its command
      if (pipeNxt[RD_LAG+b].valid && !pipeNxt[RD_LAG+b].store) begin
        outNxt = mem_r[pipeNxt[RD_LAG+b].addr][b*CRT_DATA_W +: CRT_DATA_W];
        oeNNxt = 1'b0;
      end
    end
  end

  // ****************************************
  // registers
  // ****************************************
  // link reset crosses through two stages before use
  always_ff @(posedge link.linkClk) begin
    rstS1_r <= link.linkRst;
    rstS2_r <= rstS1_r;
    if (rstS2_r) begin
      for (int k = 0; k < DEPTH; k++) begin
        pipe_r[k] <= '0;
      end
      for (int m = 0; m < CRT_MEM_DEPTH; m++) begin
        mem_r[m] <= '0;
      end
      wbuf_r <= '0;
      out_r <= '0;
      oeN_r <= 1'b1;
      storeDone_r <= 1'b0;
      doneAddr_r <= '0;
    end else begin
      pipe_r <= pipeNxt;
      mem_r <= memNxt;
      wbuf_r <= wbufNxt;
      out_r <= outNxt;
      oeN_r <= oeNNxt;
      storeDone_r <= storeDoneNxt;
      doneAddr_r <= doneAddrNxt;
    end
  end

  // outputs straight from flops
  assign link.devData = out_r;
  assign link.devDataOeN = oeN_r;
  assign storeDone = storeDone_r;
  assign doneAddr = doneAddr_r;

endmodule

// [test/crt_link_checker.sv]
// checker for the column link between the controller end and the dram end
// assumes: link signals sampled on the rising forward clock, package default lags
module crt_link_checker
  import crt_pkg::*;
(
  // forward clock and link reset
  input logic linkClk,
  input logic linkRst,
  // request wires
  input logic cmdValid,
  input logic cmdStore,
  input logic [CRT_ADDR_W-1:0] cmdAddr,
  // data lanes
  input logic [CRT_DATA_W-1:0] ctrlData,
  input logic ctrlDataOeN,
  input logic [CRT_DATA_W-1:0] devData,
  input logic devDataOeN,
  input logic [CRT_DATA_W-1:0] dataLanes
);
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************
  // sampling
  // ****************************************
  // dram end samples on the rising forward clock
  default clocking cb @(posedge linkClk);
  endclocking
  default disable iff (linkRst);

  // ****************************************
  // lags and gaps
  // ****************************************
  a_store_data_lag: assert property (
    cmdValid && cmdStore |-> ##4 !ctrlDataOeN ##1 !ctrlDataOeN)
    else $error("store packet missing four cycles after store command");
  a_fetch_data_lag: assert property (
    cmdValid && !cmdStore |-> ##7 !devDataOeN ##1 !devDataOeN)
    else $error("fetch packet missing at read data lag");
  a_store_fetch_gap: assert property (
    cmdValid && cmdStore |=> !(cmdValid && !cmdStore) [*8])
    else $error("fetch issued too soon after store");
  a_fetch_store_gap: assert property (
    cmdValid && !cmdStore |=> !(cmdValid && cmdStore) [*8])
    else $error("store issued too soon after fetch");
  a_cmd_spacing: assert property (
    cmdValid |=> !cmdValid)
    else $error("column commands closer than access cycle");
  a_lane_single_drive: assert property (
    !devDataOeN |-> ctrlDataOeN)
    else $error("both ends drive the data lanes");
  a_store_packet_len: assert property (
    $fell(ctrlDataOeN) |=> !ctrlDataOeN)
    else $error("store packet shorter than access cycle");
  a_store_fetch_bubble: assert property (
    $rose(ctrlDataOeN) |-> devDataOeN [*8])
    else $error("lane bubble after store packet too short");

  // ****************************************
  // scenario coverage
  // ****************************************
  c_store_then_fetch: cover property (cmdValid && cmdStore ##[9:12] cmdValid && !cmdStore);
  c_fetch_then_store: cover property (cmdValid && !cmdStore ##[9:12] cmdValid && cmdStore);
  c_store_pair: cover property (cmdValid && cmdStore ##2 cmdValid && cmdStore);
endmodule

// [test/tb_column_rw_turnaround_timing.sv]
// testbench joining controller end and dram end through the link interface
// assumes: package default lags; user requests driven 1 ns after the rising clk
module tb_column_rw_turnaround_timing
  import crt_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************
  // signals and expectations
  // ****************************************
  localparam int PW = CRT_DATA_W * CRT_ACC_CYC; // packet width
  localparam int EXP_FE_ST = CRT_RD_LAG_CYC - CRT_WR_LAG_CYC + CRT_ACC_CYC
                             + CRT_FE_ST_BUB_CTL_CYC + CRT_WR_FLIGHT_CYC + CRT_RD_FLIGHT_CYC;
  logic clk; // system clock
  logic rst; // synchronous reset
  logic reqValid; // user request
  logic reqStore;
  logic [CRT_ADDR_W-1:0] reqAddr;
  logic [PW-1:0] reqWdata;
  logic reqReady;
  logic rdValid; // user answer
  logic [PW-1:0] rdData;
  logic storeDone; // dram user side
  logic [CRT_ADDR_W-1:0] doneAddr;
  int errCount = 0; // mismatches
  int testsRun = 0; // comparisons
  int linkCyc = 0; // forward clock count
  int lastCmdCyc = 0;
  int gapSF = 0; // last store-to-fetch spacing
  int gapFS = 0; // last fetch-to-store spacing
  int doneCount = 0; // completed stores
  logic lastStore; // type of last command
  logic [PW-1:0] wShift = '0; // last store packet on lanes
  logic [PW-1:0] rdQ[$]; // answers seen at user side

  // ****************************************
  // design and checker
  // ****************************************
  crt_link_if linkBus ();
  crt_ctrl_end crt_ctrl_end_inst (.clk(clk), .rst(rst), .reqValid(reqValid),
    .reqStore(reqStore), .reqAddr(reqAddr), .reqWdata(reqWdata), .reqReady(reqReady),
    .rdValid(rdValid), .rdData(rdData), .link(linkBus.ctrl));
  crt_dram_end crt_dram_end_inst (.link(linkBus.dram), .storeDone(storeDone),
    .doneAddr(doneAddr));
  crt_link_checker crt_link_checker_inst (.linkClk(linkBus.linkClk),
    .linkRst(linkBus.linkRst), .cmdValid(linkBus.cmdValid), .cmdStore(linkBus.cmdStore),
    .cmdAddr(linkBus.cmdAddr), .ctrlData(linkBus.ctrlData), .ctrlDataOeN(linkBus.ctrlDataOeN),
    .devData(linkBus.devData), .devDataOeN(linkBus.devDataOeN), .dataLanes(linkBus.dataLanes));

  // clock at 40 MHz
  always #12.5 clk = ~clk;

  // ****************************************
  // monitors
  // ****************************************
  // command spacing, store beats and completions on the link
  always @(posedge linkBus.linkClk) begin
    linkCyc <= linkCyc + 1;
    if (linkBus.cmdValid === 1'b1) begin
      if (linkBus.cmdStore === 1'b1 && lastStore === 1'b0) gapFS <= linkCyc - lastCmdCyc;
      if (linkBus.cmdStore === 1'b0 && lastStore === 1'b1) gapSF <= linkCyc - lastCmdCyc;
      lastCmdCyc <= linkCyc;
      lastStore <= linkBus.cmdStore;
    end
    if (linkBus.ctrlDataOeN === 1'b0) wShift <= {linkBus.dataLanes, wShift[PW-1:CRT_DATA_W]};
    if (storeDone === 1'b1) doneCount <= doneCount + 1;
  end

  // collect answers so none is missed while a request waits
  always @(posedge clk) begin
    if (rdValid === 1'b1) rdQ.push_back(rdData);
  end

  // ****************************************
  // tasks
  // ****************************************
  // compare and count
  task automatic check(input string what, input logic [PW-1:0] seen, input logic [PW-1:0] exp);
    testsRun++;
    if (seen !== exp) begin
      errCount++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // data pattern per address
  function automatic logic [PW-1:0] pat(input int k);
    pat = {8'hC0 + k[7:0], 8'h30 + k[7:0]};
  endfunction

  // one user request, driven for a single clock once ready is seen
  task automatic send(input logic store, input int addr, input logic [PW-1:0] data);
    int n;
    n = 0;
    while (reqReady !== 1'b1 && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
    reqValid = 1'b1;
    reqStore = store;
    reqAddr = addr[CRT_ADDR_W-1:0];
    reqWdata = data;
    @(posedge clk);
    #1;
    reqValid = 1'b0;
    @(posedge clk);
    #1;
  endtask

  // next answer against expectation
  task automatic wait_read(input logic [PW-1:0] exp);
    int n;
    n = 0;
    while (rdQ.size() == 0 && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (rdQ.size() == 0) check("read answer", 'x, exp);
    else check("read data", rdQ.pop_front(), exp);
  endtask

  // verdict and end of run
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    reqValid = 1'b0;
    reqStore = 1'b0;
    reqAddr = '0;
    reqWdata = '0;
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    // back-to-back stores, then back-to-back fetches
    for (int i = 0; i < 4; i++) send(1'b1, i, pat(i));
    send(1'b0, 0, '0);
    send(1'b0, 3, '0);
    wait_read(pat(0));
    wait_read(pat(3));
    check("store lane beats", wShift, pat(3));
    check("store count", doneCount[PW-1:0], 4);
    check("last store address", doneAddr, 3);
    $display("test stream done");
    // tight store to fetch turnaround, same place
    send(1'b1, 5, pat(5));
    send(1'b0, 5, '0);
    wait_read(pat(5));
    check("store to fetch gap ok", gapSF >= CRT_ST_FE_GAP_CYC, 1'b1);
    $display("test store then fetch done");
    // tight fetch to store turnaround, other place, read back
    send(1'b0, 5, '0);
    send(1'b1, 9, pat(9));
    wait_read(pat(5));
    check("fetch to store gap ok", gapFS >= EXP_FE_ST, 1'b1);
    send(1'b0, 9, '0);
    wait_read(pat(9));
    $display("test fetch then store done");
    // second reset mid-run, then alternate on one place
    rst = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    // after the first store, each store follows its fetch at the tightest gap, before the answer is taken
    send(1'b1, 12, pat(12));
    for (int i = 0; i < 3; i++) begin
      send(1'b0, 12, '0);
      send(1'b1, 12, pat(13 + i));
      wait_read(pat(12 + i));
    end
    send(1'b0, 12, '0);
    wait_read(pat(15));
    check("alternating gap ok", gapFS >= EXP_FE_ST, 1'b1);
    $display("test alternation after reset done");
    finish_test();
  end

  // hang guard, well beyond the expected few hundred clocks
  initial begin
    repeat (20000) @(posedge clk);
    errCount++;
    $display("unexpected run length: expected done seen running");
    finish_test();
  end
endmodule
